// File: hw/drive_network_variable_io.sv
// Network-variable interface logic
// Function
// RULE1: Five switch variables drive inputs one-five
// RULE2: Switch level 0-100%, state 1/0/-1, reset zero
// RULE3: Inputs applied only when link select 2/3
// RULE4: Remote nodes avoid treating inputs as bits
// RULE5: ON trip-release write requests trip release
// RULE6: Alarm cause present keeps trip in force
// RULE7: Trip-release state returns to OFF itself
// RULE8: Speed signed percent of base, 0.005% steps
// RULE9: Send on change, period, interval, delta
// RULE10: Status bits 0-5 run, brake, bus
// RULE11: Status bits 7-12 and 15 limits, busy
// RULE12: Every read code sends parameter value
// RULE13: Write result is error, group, number
// RULE14: Successful write gives error code zero
// RULE15: Write result only after value received
// RULE16: Three analog levels 0-100% each
// RULE17: Voltage and current inputs scaled to percent
// RULE18: Analog percent ignores bias and gain
// RULE19: PID feedback percent from assigned input
// RULE20: Select 1/3 frequency, 2/3 run and inputs
// RULE21: Undefined status bits driven to zero
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module drive_network_variable_io
	import nv_io_pkg::*;
#(
	parameter int TICK = TICK_CYCLES
)
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Inverter core inputs
	input wire logic [1:0] inverter_link_select_code,
	input wire logic signed [15:0] output_freq,
	input wire logic [15:0] nominal_frequency,
	input wire drive_state_s drive_state,
	input wire logic alarm_cause,
	input wire logic [11:0] ain_raw [NUM_AIN],
	input wire logic ain2_live_zero,
	input wire logic pid_enabled,
	input wire logic [1:0] pid_fb_input,
	input wire logic param_read_ack,
	input wire logic [15:0] param_read_data,
	input wire logic param_write_done,
	input wire logic [7:0] param_write_err,
	// Inverter core outputs
	output logic [NUM_DI-1:0] digital_input_drive,
	output logic freq_cmd_enable,
	output logic trip_release_req,
	output logic param_read_req,
	output logic param_write_req,
	output logic [15:0] param_code,
	output logic [15:0] param_data,
	output logic [NUM_OUT-1:0] send_strobe
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	// Raw ADC count to 0.005% steps, full scale = 20000
	function automatic logic [15:0] to_pct(input logic [11:0] raw,
		input logic [11:0] zero);
		logic [11:0] span;
		logic [11:0] above;
		logic [27:0] prod;
		span = AIN_FULL - zero;
		above = (raw > zero) ? raw - zero : 12'h000;
		prod = 28'(above) * 28'(PCT_FULL);
		to_pct = 16'(prod / 28'(span));
	endfunction : to_pct

	function automatic logic [15:0] abs_diff(input logic [15:0] a,
		input logic [15:0] b);
		abs_diff = (a > b) ? a - b : b - a;
	endfunction : abs_diff

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [1:0] link_function_select;
	switch_nv_s di_cmd [NUM_DI];
	switch_nv_s trip_release_cmd;
	logic [15:0] param_read_code;
	logic [15:0] param_write_code;
	logic [15:0] param_write_value;
	logic [15:0] max_send_period;
	logic [15:0] min_send_interval;
	logic [15:0] min_delta_threshold;
	logic [15:0] output_speed_pct;
	logic [15:0] drive_status_word;
	logic [15:0] param_read_value;
	logic [23:0] param_write_result;
	logic [15:0] analog_in_level [NUM_AIN];
	logic [15:0] pid_feedback_level;
	logic [15:0] sent_val [NUM_OUT];
	logic [15:0] period_cnt [NUM_OUT];
	logic [15:0] gap_cnt [NUM_OUT];
	logic [NUM_OUT-1:0] read_pending;
	logic [15:0] tick_cnt;
	logic tick;
	logic [15:0] cur_val [NUM_OUT];
	logic [NUM_OUT-1:0] has_delta;
	logic wr_en;
	logic rd_en;
	logic link_di;
	logic [31:0] speed_prod;

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;
	// Card or inverter setting enables
	assign link_di = (link_function_select == LINK_RUN_DI)
		| (link_function_select == LINK_BOTH)
		| (inverter_link_select_code == LINK_RUN_DI)
		| (inverter_link_select_code == LINK_BOTH); // RULE3 RULE20

	// ------------------------------------------------------------
	// APB write side
	// ------------------------------------------------------------
	// Command variables and send configuration
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link_function_select <= 2'h0;
			for (int i = 0; i < NUM_DI; i++)
				di_cmd[i] <= '{state: STATE_OFF, level: LEVEL_RESET}; // RULE2
			param_read_code <= 16'h0000;
			param_write_code <= 16'h0000;
			param_write_value <= 16'h0000;
			max_send_period <= PERIOD_RESET;
			min_send_interval <= PERIOD_RESET;
			min_delta_threshold <= PERIOD_RESET;
		end
		else if (wr_en)
		begin
			if (paddr == REG_CTRL)
				link_function_select <= pwdata[1:0];
			else if (paddr >= REG_DI_CMD_BASE && paddr < REG_TRIP_CMD)
			begin
				// Bad level or state ignored
				if (pwdata[7:0] <= LEVEL_FULL && (pwdata[15:8] == STATE_ON
					|| pwdata[15:8] == STATE_OFF
					|| pwdata[15:8] == STATE_NULL)) // RULE2
					di_cmd[3'((paddr - REG_DI_CMD_BASE) >> 2)] <=
						pwdata[15:0]; // RULE1
			end
			else if (paddr == REG_PARAM_READ)
				param_read_code <= pwdata[15:0];
			else if (paddr == REG_PARAM_WCODE)
				param_write_code <= pwdata[15:0];
			else if (paddr == REG_PARAM_WVAL)
				param_write_value <= pwdata[15:0];
			else if (paddr == REG_SEND_TIMING)
			begin
				max_send_period <= pwdata[15:0];
				min_send_interval <= pwdata[31:16];
			end
			else if (paddr == REG_DELTA)
				min_delta_threshold <= pwdata[15:0];
		end
	end

	// One-shot trip release; state falls back to OFF
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trip_release_cmd <= '{state: STATE_OFF, level: LEVEL_RESET};
			trip_release_req <= 1'b0;
		end
		else if (wr_en && paddr == REG_TRIP_CMD
			&& pwdata[15:8] == STATE_ON)
		begin
			trip_release_cmd <= pwdata[15:0];
			trip_release_req <= ~alarm_cause; // RULE5 RULE6
		end
		else
		begin
			trip_release_cmd.state <= STATE_OFF; // RULE7
			trip_release_req <= 1'b0;
		end
	end

	// Parameter access requests toward the inverter core
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			param_read_req <= 1'b0;
			param_write_req <= 1'b0;
			param_code <= 16'h0000;
			param_data <= 16'h0000;
		end
		else
		begin
			param_read_req <= wr_en && paddr == REG_PARAM_READ; // RULE12
			// Only the value write starts it
			param_write_req <= wr_en && paddr == REG_PARAM_WVAL; // RULE15
			if (wr_en && paddr == REG_PARAM_READ)
				param_code <= pwdata[15:0];
			else if (wr_en && paddr == REG_PARAM_WVAL)
			begin
				param_code <= param_write_code;
				param_data <= pwdata[15:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Inverter to network values
	// ------------------------------------------------------------
	assign speed_prod = 32'($signed(output_freq) * $signed(32'(PCT_FULL)));

	// Sampled monitor values
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			output_speed_pct <= 16'h0000;
			drive_status_word <= 16'h0000;
			param_read_value <= 16'h0000;
			param_write_result <= 24'h000000;
			pid_feedback_level <= 16'h0000;
			for (int i = 0; i < NUM_AIN; i++)
				analog_in_level[i] <= 16'h0000;
		end
		else
		begin
			// Zero base frequency freezes the value
			if (nominal_frequency != 16'h0000)
				output_speed_pct <= 16'($signed(speed_prod)
					/ $signed({16'h0000, nominal_frequency})); // RULE8
			drive_status_word <= {drive_state.busy_writing, STATUS_SPARE,
				drive_state.comm_active_bit, drive_state.alarm_relay_bit,
				drive_state.decelerating_bit, drive_state.accelerating_bit,
				drive_state.current_limit_bit,
				drive_state.voltage_limit_bit, STATUS_BIT6,
				drive_state.bus_voltage_ok_bit, drive_state.braking_bit,
				drive_state.shutdown, drive_state.dc_brake_bit,
				drive_state.reverse_run_bit,
				drive_state.forward_run_bit}; // RULE10 RULE11 RULE21
			if (param_read_ack)
				param_read_value <= param_read_data;
			if (param_write_done)
				param_write_result <= {param_write_err,
					param_code}; // RULE13 RULE14
			// Raw count only, no bias or gain
			analog_in_level[0] <= to_pct(ain_raw[0], 12'h000); // RULE16
			analog_in_level[1] <= to_pct(ain_raw[1],
				ain2_live_zero ? AIN_4MA : 12'h000); // RULE17 RULE18
			analog_in_level[2] <= to_pct(ain_raw[2], 12'h000); // RULE17
			if (pid_enabled && pid_fb_input != 2'h0
				&& pid_fb_input <= 2'(NUM_AIN))
				pid_feedback_level <= to_pct(ain_raw[pid_fb_input - 2'h1],
					12'h000); // RULE19
			else
				pid_feedback_level <= 16'h0000;
		end
	end

	// Digital inputs follow switch state when the link permits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			digital_input_drive <= '0;
			freq_cmd_enable <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < NUM_DI; i++)
				digital_input_drive[i] <= link_di
					&& di_cmd[i].state == STATE_ON; // RULE1 RULE3
			freq_cmd_enable <= (link_function_select == LINK_FREQ)
				| (link_function_select == LINK_BOTH)
				| (inverter_link_select_code == LINK_FREQ)
				| (inverter_link_select_code == LINK_BOTH); // RULE20
		end
	end

	// ------------------------------------------------------------
	// Send scheduler (index 0 speed, 1 status, 2 read value,
	// 3-5 analog levels, 6 PID); unit of timing is one tick
	// ------------------------------------------------------------
	always_comb
	begin
		cur_val[0] = output_speed_pct;
		cur_val[1] = drive_status_word;
		cur_val[2] = param_read_value;
		cur_val[3] = analog_in_level[0];
		cur_val[4] = analog_in_level[1];
		cur_val[5] = analog_in_level[2];
		cur_val[6] = pid_feedback_level;
		has_delta = 7'b1111001;
	end

	// Millisecond tick
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_cnt <= 16'h0000;
			tick <= 1'b0;
		end
		else
		begin
			tick <= tick_cnt == 16'(TICK - 1);
			tick_cnt <= (tick_cnt == 16'(TICK - 1)) ? 16'h0000
				: tick_cnt + 16'h0001;
		end
	end

	// Per-output send decision
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			send_strobe <= '0;
			read_pending <= '0;
			for (int i = 0; i < NUM_OUT; i++)
			begin
				sent_val[i] <= 16'h0000;
				period_cnt[i] <= 16'h0000;
				gap_cnt[i] <= 16'h0000;
			end
		end
		else
		begin
			// Read results go out even if unchanged
			if (param_read_ack)
				read_pending[2] <= 1'b1; // RULE12
			for (int i = 0; i < NUM_OUT; i++)
			begin
				logic due;
				logic changed;
				due = 1'b0;
				changed = (i == 2) ? read_pending[i]
					: (has_delta[i] && min_delta_threshold != 16'h0000)
					? abs_diff(cur_val[i], sent_val[i]) >= min_delta_threshold
					: cur_val[i] != sent_val[i];
				if (max_send_period != 16'h0000
					&& period_cnt[i] >= max_send_period)
					due = 1'b1;
				if (changed)
					due = 1'b1;
				// Minimum interval holds sends back
				if (due && gap_cnt[i] >= min_send_interval) // RULE9
				begin
					send_strobe[i] <= 1'b1;
					sent_val[i] <= cur_val[i];
					period_cnt[i] <= 16'h0000;
					gap_cnt[i] <= 16'h0000;
					if (i == 2 && !param_read_ack)
						read_pending[2] <= 1'b0;
				end
				else
				begin
					send_strobe[i] <= 1'b0;
					if (tick && period_cnt[i] != 16'hFFFF)
						period_cnt[i] <= period_cnt[i] + 16'h0001;
					if (tick && gap_cnt[i] != 16'hFFFF)
						gap_cnt[i] <= gap_cnt[i] + 16'h0001;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// APB read side, one wait-free access phase
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel & ~penable)
			begin
				prdata <= 32'h00000000;
				if (paddr[1:0] != 2'h0 || paddr > REG_SEND_FLAGS)
					pslverr <= 1'b1;
				else if (!rd_en)
					prdata <= 32'h00000000;
				else if (paddr == REG_CTRL)
					prdata <= {30'h0, link_function_select};
				else if (paddr >= REG_DI_CMD_BASE && paddr < REG_TRIP_CMD)
					prdata <= {16'h0,
						di_cmd[3'((paddr - REG_DI_CMD_BASE) >> 2)]};
				else if (paddr == REG_TRIP_CMD)
					prdata <= {16'h0, trip_release_cmd};
				else if (paddr == REG_PARAM_READ)
					prdata <= {16'h0, param_read_code};
				else if (paddr == REG_PARAM_WCODE)
					prdata <= {16'h0, param_write_code};
				else if (paddr == REG_PARAM_WVAL)
					prdata <= {16'h0, param_write_value};
				else if (paddr == REG_SEND_TIMING)
					prdata <= {min_send_interval, max_send_period};
				else if (paddr == REG_DELTA)
					prdata <= {16'h0, min_delta_threshold};
				else if (paddr == REG_SPEED)
					prdata <= {16'h0, output_speed_pct};
				else if (paddr == REG_STATUS)
					prdata <= {16'h0, drive_status_word};
				else if (paddr == REG_READ_VAL)
					prdata <= {16'h0, param_read_value};
				else if (paddr == REG_WRESULT)
					prdata <= {8'h0, param_write_result};
				else if (paddr >= REG_AIN_BASE && paddr < REG_PID)
					prdata <= {16'h0,
						analog_in_level[2'((paddr - REG_AIN_BASE) >> 2)]};
				else if (paddr == REG_PID)
					prdata <= {16'h0, pid_feedback_level};
				else
					prdata <= {25'h0, send_strobe};
			end
		end
	end

endmodule : drive_network_variable_io

// File: hw/nv_io_pkg.sv
// Constants and carriers for the network-variable block
package nv_io_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_DI_CMD_BASE = 8'h04;
	localparam logic [7:0] REG_TRIP_CMD = 8'h18;
	localparam logic [7:0] REG_PARAM_READ = 8'h1C;
	localparam logic [7:0] REG_PARAM_WCODE = 8'h20;
	localparam logic [7:0] REG_PARAM_WVAL = 8'h24;
	localparam logic [7:0] REG_SEND_TIMING = 8'h28;
	localparam logic [7:0] REG_DELTA = 8'h2C;
	localparam logic [7:0] REG_SPEED = 8'h30;
	localparam logic [7:0] REG_STATUS = 8'h34;
	localparam logic [7:0] REG_READ_VAL = 8'h38;
	localparam logic [7:0] REG_WRESULT = 8'h3C;
	localparam logic [7:0] REG_AIN_BASE = 8'h40;
	localparam logic [7:0] REG_PID = 8'h4C;
	localparam logic [7:0] REG_SEND_FLAGS = 8'h50;

	// ------------------------------------------------------------
	// Field layouts and reset values
	// ------------------------------------------------------------
	localparam int NUM_DI = 5;
	localparam int NUM_AIN = 3;
	localparam int NUM_OUT = 7;
	localparam int STATE_LSB = 8;
	localparam logic [7:0] LEVEL_RESET = 8'h00;
	localparam logic [7:0] STATE_ON = 8'h01;
	localparam logic [7:0] STATE_OFF = 8'h00;
	localparam logic [7:0] STATE_NULL = 8'hFF;
	localparam logic [7:0] LEVEL_FULL = 8'hC8;
	localparam logic [1:0] LINK_RUN_DI = 2'h2;
	localparam logic [1:0] LINK_BOTH = 2'h3;
	localparam logic [1:0] LINK_FREQ = 2'h1;
	localparam logic [15:0] PCT_FULL = 16'h4E20;
	localparam logic [15:0] PCT_PID_MAX = 16'h7FFE;
	localparam logic [11:0] AIN_FULL = 12'hFFF;
	localparam logic [11:0] AIN_4MA = 12'h333;
	localparam logic [7:0] WRITE_OK = 8'h00;
	localparam logic [1:0] STATUS_SPARE = 2'h0;
	localparam logic STATUS_BIT6 = 1'b0;
	localparam logic [15:0] PERIOD_RESET = 16'h0000;
	localparam int TICK_US = 1000;
	localparam int CLK_MHZ = 10;
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

	// Switch-type command variable: level in 0.5 % steps and state
	typedef struct packed {
		logic [7:0] state;
		logic [7:0] level;
	} switch_nv_s;

	// Inverter status inputs that make up the drive status word
	typedef struct packed {
		logic busy_writing;
		logic comm_active_bit;
		logic alarm_relay_bit;
		logic decelerating_bit;
		logic accelerating_bit;
		logic current_limit_bit;
		logic voltage_limit_bit;
		logic bus_voltage_ok_bit;
		logic braking_bit;
		logic shutdown;
		logic dc_brake_bit;
		logic reverse_run_bit;
		logic forward_run_bit;
	} drive_state_s;

endpackage : nv_io_pkg

// File: sim/nv_io_checker_assertions.sv
// Port-level checker for the network-variable block
`timescale 1ns/1ps
module nv_io_checker
	import nv_io_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// Inverter side
	input wire logic [1:0] inverter_link_select_code,
	input wire drive_state_s drive_state,
	input wire logic alarm_cause,
	input wire logic freq_cmd_enable,
	input wire logic trip_release_req,
	input wire logic param_read_req,
	input wire logic param_write_req,
	input wire logic [15:0] param_data
);
	// ------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------
	// Access phases
	logic wr_acc;
	logic rd_acc;
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite && pready;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_NO_WAIT: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	AST_FREQ_EN: assert property (
		$past(presetn, 2) && inverter_link_select_code[0]
		&& $past(inverter_link_select_code[0]) |-> freq_cmd_enable)
		else $error("frequency command not enabled");
	AST_TRIP_CAUSE: assert property (
		trip_release_req |-> $past(wr_acc && paddr == REG_TRIP_CMD
		&& pwdata[15:8] == STATE_ON && !alarm_cause))
		else $error("trip release without clean ON write");
	AST_TRIP_PULSE: assert property (
		trip_release_req |=> !trip_release_req)
		else $error("trip release held over");
	AST_WR_CAUSE: assert property (
		param_write_req |-> $past(wr_acc && paddr == REG_PARAM_WVAL))
		else $error("parameter write without value");
	AST_WR_EVERY: assert property (
		wr_acc && paddr == REG_PARAM_WVAL
		|=> param_write_req && param_data == $past(pwdata[15:0]))
		else $error("value write not forwarded");
	AST_RD_CAUSE: assert property (
		param_read_req |-> $past(wr_acc && paddr == REG_PARAM_READ))
		else $error("parameter read without code");
	AST_RD_EVERY: assert property (
		wr_acc && paddr == REG_PARAM_READ |=> param_read_req)
		else $error("read code not forwarded");
	AST_STATUS: assert property (
		rd_acc && paddr == REG_STATUS && $stable(drive_state)
		&& drive_state == $past(drive_state, 2)
		&& drive_state == $past(drive_state, 3)
		|-> prdata[14:0] == {2'b00, drive_state[11:6], 1'b0,
		drive_state[5:0]})
		else $error("status word layout wrong");
	AST_AIN_RANGE: assert property (
		rd_acc && paddr >= REG_AIN_BASE && paddr < REG_PID
		|-> prdata[15:0] <= PCT_FULL)
		else $error("analog level above full scale");
	AST_PID_RANGE: assert property (
		rd_acc && paddr == REG_PID |-> prdata[15:0] <= PCT_PID_MAX)
		else $error("feedback level above range");
endmodule : nv_io_checker

bind drive_network_variable_io nv_io_checker nv_io_checker_inst (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .inverter_link_select_code, .drive_state,
	.alarm_cause, .freq_cmd_enable, .trip_release_req,
	.param_read_req, .param_write_req, .param_data
);

// File: sim/inverter_core_model.sv
// Behavioural inverter core answering parameter reads and writes
`timescale 1ns/1ps
module inverter_core_model
	import nv_io_pkg::*;
(
	// Clock, reset and answer speed
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	// Requests from the block
	input wire logic param_read_req,
	input wire logic param_write_req,
	input wire logic [15:0] param_code,
	input wire logic [15:0] param_data,
	// Answers to the block
	output logic param_read_ack,
	output logic [15:0] param_read_data,
	output logic param_write_done,
	output logic [7:0] param_write_err
);
	logic [3:0] rd_wait;
	logic [3:0] wr_wait;
	logic [15:0] rd_val;
	logic [7:0] wr_val;

	// Answer after one or six cycles; data toggles off the ack
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_wait <= 4'h0;
			wr_wait <= 4'h0;
			rd_val <= 16'h0000;
			wr_val <= 8'h00;
			param_read_ack <= 1'b0;
			param_read_data <= 16'h0000;
			param_write_done <= 1'b0;
			param_write_err <= 8'h00;
		end
		else
		begin
			param_read_ack <= 1'b0;
			param_write_done <= 1'b0;
			param_read_data <= ~param_read_data;
			param_write_err <= ~param_write_err;
			if (param_read_req)
			begin
				rd_wait <= slow ? 4'h6 : 4'h1;
				rd_val <= param_code ^ 16'hA5A5;
			end
			else if (rd_wait != 4'h0)
				rd_wait <= rd_wait - 4'h1;
			if (rd_wait == 4'h1 && !param_read_req)
			begin
				param_read_ack <= 1'b1;
				param_read_data <= rd_val;
			end
			if (param_write_req)
			begin
				wr_wait <= slow ? 4'h6 : 4'h1;
				wr_val <= (param_data == 16'hFFFF) ? 8'h02 : WRITE_OK;
			end
			else if (wr_wait != 4'h0)
				wr_wait <= wr_wait - 4'h1;
			if (wr_wait == 4'h1 && !param_write_req)
			begin
				param_write_done <= 1'b1;
				param_write_err <= wr_val;
			end
		end
	end
endmodule : inverter_core_model

// File: sim/tb_top.sv
// Self-checking bench for the network-variable block
`timescale 1ns/1ps
module tb_top
	import nv_io_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, slow = 1'b0;
	logic [1:0] inverter_link_select_code = 2'h0;
	logic signed [15:0] output_freq = 16'sd0;
	logic [15:0] nominal_frequency = 16'd600;
	drive_state_s drive_state = '0;
	logic alarm_cause = 1'b0;
	logic [11:0] ain_raw [NUM_AIN] = '{12'h0, 12'h0, 12'h0};
	logic ain2_live_zero = 1'b0;
	logic pid_enabled = 1'b0;
	logic [1:0] pid_fb_input = 2'h0;
	logic param_read_ack, param_write_done;
	logic [15:0] param_read_data, param_code, param_data;
	logic [7:0] param_write_err;
	logic [NUM_DI-1:0] digital_input_drive;
	logic freq_cmd_enable, trip_release_req;
	logic param_read_req, param_write_req;
	logic [NUM_OUT-1:0] send_strobe;
	int n_errors = 0;
	int num_checks = 0;
	int trips = 0, sends = 0, speeds = 0, wreqs = 0, dones = 0, acks = 0;

	drive_network_variable_io #(.TICK(10)) drive_network_variable_io_inst (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .inverter_link_select_code,
		.output_freq, .nominal_frequency, .drive_state, .alarm_cause,
		.ain_raw, .ain2_live_zero, .pid_enabled, .pid_fb_input,
		.param_read_ack, .param_read_data, .param_write_done,
		.param_write_err, .digital_input_drive, .freq_cmd_enable,
		.trip_release_req, .param_read_req, .param_write_req,
		.param_code, .param_data, .send_strobe);
	inverter_core_model inverter_core_model_inst (.pclk, .presetn, .slow,
		.param_read_req, .param_write_req, .param_code, .param_data,
		.param_read_ack, .param_read_data, .param_write_done,
		.param_write_err);

	// 10 MHz clock
	always #50 pclk = ~pclk;

	// Pulse counters
	always @(posedge pclk)
	begin
		trips <= trips + (trip_release_req === 1'b1);
		sends <= sends + (send_strobe[2] === 1'b1);
		speeds <= speeds + (send_strobe[0] === 1'b1);
		wreqs <= wreqs + (param_write_req === 1'b1);
		dones <= dones + (param_write_done === 1'b1);
		acks <= acks + (param_read_ack === 1'b1);
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic conclude;
		if (n_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// One APB transfer, edge aligned
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] v, output logic e);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		v = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (i == 20)
		begin
			n_errors++;
			conclude();
		end
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		logic e;
		apb(1'b1, a, d, v, e);
	endtask : wr

	task automatic rd_chk(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		logic [31:0] v;
		logic e;
		apb(1'b0, a, 32'h0, v, e);
		check(what, exp, v);
	endtask : rd_chk

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask : idle

	// Bounded wait on a pulse counter
	task automatic wait_cnt(ref int c, input int n);
		int i;
		for (i = 0; i < 60 && c < n; i++)
			@(posedge pclk);
		if (c < n)
		begin
			n_errors++;
			conclude();
		end
	endtask : wait_cnt

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic s_inputs;
		rd_chk("di1_reset", REG_DI_CMD_BASE, 32'h0);
		wr(REG_CTRL, 32'h2);
		wr(8'h0C, {16'h0, STATE_ON, LEVEL_FULL});
		idle(3);
		check("di_order", 32'h4, digital_input_drive);
		wr(8'h0C, 32'h0501);
		rd_chk("di_keep", 8'h0C, 32'h01C8);
		for (int k = 0; k < NUM_DI; k++)
			wr(REG_DI_CMD_BASE + 8'(4 * k), 32'h0164);
		for (int s = 0; s < 4; s++)
		begin
			wr(REG_CTRL, s);
			idle(3);
			check("di_card", (s >= 2) ? 32'h1F : 32'h0, digital_input_drive);
		end
		wr(REG_CTRL, 32'h0);
		inverter_link_select_code <= LINK_BOTH;
		wr(REG_DI_CMD_BASE, {16'h0, STATE_NULL, 8'h00});
		idle(3);
		check("di_inv", 32'h1E, digital_input_drive);
		check("freq_en", 32'h1, freq_cmd_enable);
		inverter_link_select_code <= LINK_FREQ;
		idle(3);
		check("di_freq_only", 32'h0, digital_input_drive);
	endtask : s_inputs

	task automatic s_trip;
		alarm_cause <= 1'b1;
		wr(REG_TRIP_CMD, {16'h0, STATE_ON, LEVEL_FULL});
		idle(3);
		check("trip_held", 32'h0, trips);
		alarm_cause <= 1'b0;
		wr(REG_TRIP_CMD, {16'h0, STATE_ON, LEVEL_FULL});
		idle(3);
		check("trip_req", 32'h1, trips);
		rd_chk("trip_off", REG_TRIP_CMD, 32'h00C8);
	endtask : s_trip

	task automatic s_param;
		wr(REG_PARAM_READ, 32'h0C0E);
		wait_cnt(acks, 1);
		idle(3);
		rd_chk("rd_val", REG_READ_VAL, 32'hA9AB);
		slow <= 1'b1;
		wr(REG_PARAM_READ, 32'h0C0E);
		wait_cnt(acks, 2);
		idle(3);
		check("rd_sent", 32'h2, sends);
		wr(REG_PARAM_WCODE, 32'h0C05);
		idle(8);
		check("wr_early", 32'h0, wreqs);
		wr(REG_PARAM_WVAL, 32'h1388);
		wait_cnt(dones, 1);
		idle(2);
		rd_chk("wres_ok", REG_WRESULT, 32'h000C05);
		wr(REG_PARAM_WVAL, 32'hFFFF);
		wait_cnt(dones, 2);
		idle(2);
		rd_chk("wres_err", REG_WRESULT, 32'h020C05);
	endtask : s_param

	task automatic s_monitor;
		output_freq <= 16'sd300;
		drive_state <= 13'h15A7;
		ain_raw <= '{AIN_FULL, AIN_4MA, 12'h000};
		ain2_live_zero <= 1'b1;
		pid_enabled <= 1'b1;
		pid_fb_input <= 2'h1;
		idle(8);
		rd_chk("speed", REG_SPEED, 32'h2710);
		rd_chk("status", REG_STATUS, 32'h8B27);
		rd_chk("ain1", REG_AIN_BASE, PCT_FULL);
		rd_chk("ain2", 8'h44, 32'h0);
		rd_chk("ain3", 8'h48, 32'h0);
		rd_chk("pid", REG_PID, PCT_FULL);
		output_freq <= -16'sd300;
		idle(8);
		rd_chk("speed_neg", REG_SPEED, 32'hD8F0);
	endtask : s_monitor

	task automatic s_timing;
		int base;
		logic [31:0] v;
		logic e;
		wr(REG_SEND_TIMING, 32'h0000_0002);
		base = speeds;
		idle(100);
		check("periodic", 32'h1, 32'(speeds - base inside {[4:6]}));
		wr(REG_SEND_TIMING, 32'h0005_0000);
		base = speeds;
		repeat (100)
		begin
			output_freq <= output_freq + 16'sd1;
			@(posedge pclk);
		end
		check("min_gap", 32'h1, 32'(speeds - base inside {[1:3]}));
		apb(1'b0, 8'h54, 32'h0, v, e);
		check("unmapped", 32'h1, e);
	endtask : s_timing

	// Reset, then scenarios
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		s_inputs();
		s_trip();
		s_param();
		s_monitor();
		s_timing();
		conclude();
	end
endmodule : tb_top
